// ### verilog/dpm_mute_arb.sv
// mute control and serial/pushbutton arbitration for two audio pots
`default_nettype none
module dpm_mute_arb #(
   parameter int DEBOUNCE_CYCLES = dpm_pkg::DEBOUNCE_CYCLES
) (
   input  wire logic                          CORE_CLK_I,
   input  wire logic                          RSTN_I,
   // wishbone slave
   input  wire logic                          WB_CYC_I,
   input  wire logic                          WB_STB_I,
   input  wire logic                          WB_WE_I,
   input  wire logic [dpm_pkg::ADR_W-1:0]     WB_ADR_I,
   input  wire logic [3:0]                    WB_SEL_I,
   input  wire logic [31:0]                   WB_DAT_I,
   output logic      [31:0]                   WB_DAT_O,
   output logic                               WB_ACK_O,
   // three-wire serial port, its clock is the link domain
   input  wire logic                          SER_CLK_I,
   input  wire logic                          SER_EN_I,
   input  wire logic                          SER_DATA_I,
   // contact inputs, active low
   input  wire logic                          MUTE_N_I,
   input  wire logic                          VOLUME_UP_BUTTON_N_I,
   input  wire logic                          VOLUME_DOWN_BUTTON_N_I,
   input  wire logic                          CHAN0_UP_BUTTON_N_I,
   input  wire logic                          CHAN0_DOWN_BUTTON_N_I,
   input  wire logic                          CHAN1_UP_BUTTON_N_I,
   input  wire logic                          CHAN1_DOWN_BUTTON_N_I,
   // wiper controls to the analog arrays
   output logic      [dpm_pkg::POS_W-1:0]     WIPER0_POS_O,
   output logic      [dpm_pkg::POS_W-1:0]     WIPER1_POS_O,
   output logic                               WIPER0_LOW_O,
   output logic                               WIPER1_LOW_O
);

   // serial tracking states in the core domain
   typedef enum logic [0:0] {
      DPM_SER_IDLE,
      DPM_SER_BUSY
   } dpm_ser_state_t;

   logic                          rst_s1_reg;     // reset release stage one
   logic                          rst_n;          // released reset copy
   logic [dpm_pkg::WORD_W-1:0]    shift_reg;      // link-domain shift word
   logic                          en_s1_reg;      // enable sync stage one
   logic                          en_s2_reg;      // enable sync stage two
   logic                          en_s3_reg;      // enable sync stage three
   dpm_ser_state_t                ser_reg;        // serial tracking state
   dpm_ser_state_t                ser_next;
   logic                          load;           // enable fell: take word
   logic                          ser_busy;       // serial activity seen
   logic [dpm_pkg::WORD_W-1:0]    word_reg;       // last loaded word
   logic                          loaded_reg;     // a word has been loaded
   logic [dpm_pkg::POS_W-1:0]     pos0_reg;       // channel 0 wiper setting
   logic [dpm_pkg::POS_W-1:0]     pos1_reg;       // channel 1 wiper setting
   logic                          sw_mute0_reg;   // software mute channel 0
   logic                          sw_mute1_reg;   // software mute channel 1
   logic                          hw_mute_reg;    // hardware mute state
   logic                          pb_en_reg;      // pushbutton mode enable
   logic                          hw_clr_req;     // software clears hw mute
   logic [dpm_pkg::IN_N-1:0]      raw_n;          // contact inputs
   logic [dpm_pkg::IN_N-1:0]      press;          // debounced press pulses
   logic                          pb_ok;          // buttons may act now
   logic                          any_btn;        // accepted button press
   logic                          up0;            // step channel 0 up
   logic                          dn0;            // step channel 0 down
   logic                          up1;            // step channel 1 up
   logic                          dn1;            // step channel 1 down
   logic                          bus_req;        // new wishbone request
   logic [31:0]                   rd_data;        // read mux result

   // one saturating step of a wiper; up wins no tie, opposite presses cancel
   function automatic logic [dpm_pkg::POS_W-1:0] step_pos(
      input logic [dpm_pkg::POS_W-1:0] pos,
      input logic                      up,
      input logic                      dn
   );
      logic [dpm_pkg::POS_W-1:0] r;
      // ends and ties leave the position alone
      r = pos;
      if (up && !dn && pos != dpm_pkg::POS_MAX) begin
         r = pos + dpm_pkg::POS_ONE;
      end else if (dn && !up && pos != dpm_pkg::POS_MIN) begin
         r = pos - dpm_pkg::POS_ONE;
      end
      return r;
   endfunction

   // reset release through two flops
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         // pin low: internal reset asserts at once
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         // release ripples through two edges
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   // link domain: shift data in while enable is high, lsb arrives first
   // the clock stands between frames, so the word holds still for the core
   always_ff @(posedge SER_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         // partial word discarded
         shift_reg <= dpm_pkg::WORD_RESET;
      end else if (SER_EN_I) begin
         // one bit per rising serial clock
         shift_reg <= {SER_DATA_I, shift_reg[dpm_pkg::WORD_W-1:1]};
      end
   end

   // enable level crosses into the core domain through three flops
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         // enable reads low during reset
         en_s1_reg <= 1'b0;
         en_s2_reg <= 1'b0;
         en_s3_reg <= 1'b0;
      end else begin
         en_s1_reg <= SER_EN_I;
         en_s2_reg <= en_s1_reg;
         en_s3_reg <= en_s2_reg;
      end
   end

   // serial tracking: busy once stages agree high, idle once they agree low
   always_comb begin
      ser_next = ser_reg;
      load     = 1'b0;
      unique case (ser_reg)
         DPM_SER_IDLE: begin
            // wait until both stages show the enable high
            if (en_s2_reg && en_s3_reg) begin
               ser_next = DPM_SER_BUSY;
            end
         end
         DPM_SER_BUSY: begin
            // both stages low: the frame is over
            if (!en_s2_reg && !en_s3_reg) begin
               ser_next = DPM_SER_IDLE;
               load     = 1'b1;
            end
         end
      endcase
   end

   // state register for serial tracking
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         ser_reg <= DPM_SER_IDLE;
      end else begin
         ser_reg <= ser_next;
      end
   end

   // the enable high at stage two or three, or the busy state, counts as serial activity
   assign ser_busy = (ser_reg == DPM_SER_BUSY) || en_s2_reg || en_s3_reg;

   // take the shifted word when the enable has fallen
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         word_reg   <= dpm_pkg::WORD_RESET;
         loaded_reg <= 1'b0;
      end else if (load) begin
         // kept for read-back until the next frame ends
         word_reg   <= shift_reg;
         loaded_reg <= 1'b1;
      end
   end

   // gather contact inputs, mute pin last
   assign raw_n = {MUTE_N_I,
                   CHAN1_DOWN_BUTTON_N_I,
                   CHAN1_UP_BUTTON_N_I,
                   CHAN0_DOWN_BUTTON_N_I,
                   CHAN0_UP_BUTTON_N_I,
                   VOLUME_DOWN_BUTTON_N_I,
                   VOLUME_UP_BUTTON_N_I};

   // one debouncer per contact, mute pin treated like the buttons
   for (genvar i = 0; i < dpm_pkg::IN_N; i++) begin : g_deb
      // steady levels are not needed, only presses
      dpm_debounce #(
         .DEB_CYCLES (DEBOUNCE_CYCLES)
      ) u_deb (
         .clk_i     (CORE_CLK_I),
         .rst_n_i   (rst_n),
         .raw_n_i   (raw_n[i]),
         .level_n_o (),
         .press_o   (press[i])
      );
   end

   // buttons act only in pushbutton mode and outside serial activity
   assign pb_ok   = pb_en_reg && !ser_busy && !load;
   assign any_btn = pb_ok && (|press[dpm_pkg::BTN_N-1:0]);
   assign up0     = press[dpm_pkg::BTN_VOL_UP] || press[dpm_pkg::BTN_C0_UP];
   assign dn0     = press[dpm_pkg::BTN_VOL_DN] || press[dpm_pkg::BTN_C0_DN];
   assign up1     = press[dpm_pkg::BTN_VOL_UP] || press[dpm_pkg::BTN_C1_UP];
   assign dn1     = press[dpm_pkg::BTN_VOL_DN] || press[dpm_pkg::BTN_C1_DN];

   // wiper settings: serial load first, then buttons
   // hardware mute never touches these, so unmuting restores them
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         // both wipers start at the low end
         pos0_reg <= dpm_pkg::POS_RESET;
         pos1_reg <= dpm_pkg::POS_RESET;
      end else if (load) begin
         // serial word sets both wipers
         pos0_reg <= shift_reg[dpm_pkg::CH0_POS_LSB +: dpm_pkg::POS_W];
         pos1_reg <= shift_reg[dpm_pkg::CH1_POS_LSB +: dpm_pkg::POS_W];
      end else if (pb_ok) begin
         // button steps, blocked during serial activity
         pos0_reg <= step_pos(pos0_reg, up0, dn0);
         pos1_reg <= step_pos(pos1_reg, up1, dn1);
      end
   end

   // software mute flags change only with a new loaded word
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         // no channel muted by software after reset
         sw_mute0_reg <= 1'b0;
         sw_mute1_reg <= 1'b0;
      end else if (load) begin
         // a cleared flag releases its channel
         sw_mute0_reg <= shift_reg[dpm_pkg::CH0_MUTE_BIT];
         sw_mute1_reg <= shift_reg[dpm_pkg::CH1_MUTE_BIT];
      end
   end

   // hardware mute: toggled by the pin, cancelled by buttons or software
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         hw_mute_reg <= 1'b0;
      end else if (press[dpm_pkg::IN_MUTE]) begin
         // pin press wins over a cancel in the same cycle
         hw_mute_reg <= ~hw_mute_reg;
      end else if (any_btn || hw_clr_req) begin
         // button press or software clear cancels
         hw_mute_reg <= 1'b0;
      end
   end

   // outputs: a channel is grounded when either mute source asks for it
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         // unmuted at the low end after reset
         WIPER0_POS_O <= dpm_pkg::POS_RESET;
         WIPER1_POS_O <= dpm_pkg::POS_RESET;
         WIPER0_LOW_O <= 1'b0;
         WIPER1_LOW_O <= 1'b0;
      end else begin
         // settings reach the pins one cycle later
         WIPER0_POS_O <= pos0_reg;
         WIPER1_POS_O <= pos1_reg;
         WIPER0_LOW_O <= hw_mute_reg || sw_mute0_reg;
         WIPER1_LOW_O <= hw_mute_reg || sw_mute1_reg;
      end
   end

   // a request is new while no ack is out for it
   assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;

   // control register; the clear bit is a write-one pulse, never stored
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         // pushbutton mode on after reset
         pb_en_reg <= dpm_pkg::CTRL_PB_EN_RESET;
      end else if (bus_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == dpm_pkg::ADR_CTRL) begin
         // control bits sit in byte lane 0
         pb_en_reg <= WB_DAT_I[dpm_pkg::CTRL_PB_EN_BIT];
      end
   end

   assign hw_clr_req = bus_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == dpm_pkg::ADR_CTRL
                       && WB_DAT_I[dpm_pkg::CTRL_HW_CLR_BIT];

   // read mux; unmapped addresses read zero
   always_comb begin
      rd_data = dpm_pkg::DATA_ZERO;
      unique case (WB_ADR_I)
         dpm_pkg::ADR_CTRL: begin
            // the clear bit always reads zero
            rd_data[dpm_pkg::CTRL_PB_EN_BIT] = pb_en_reg;
         end
         dpm_pkg::ADR_STATUS: begin
            // live state, nothing clears on read
            rd_data[dpm_pkg::ST_HW_MUTE_BIT]  = hw_mute_reg;
            rd_data[dpm_pkg::ST_SER_BUSY_BIT] = ser_busy;
            rd_data[dpm_pkg::ST_MUTE0_BIT]    = hw_mute_reg || sw_mute0_reg;
            rd_data[dpm_pkg::ST_MUTE1_BIT]    = hw_mute_reg || sw_mute1_reg;
            rd_data[dpm_pkg::ST_LOADED_BIT]   = loaded_reg;
         end
         dpm_pkg::ADR_WORD: begin
            // upper half reads zero
            rd_data[dpm_pkg::WORD_W-1:0] = word_reg;
         end
         default: begin
            rd_data = dpm_pkg::DATA_ZERO;
         end
      endcase
   end

   // one-cycle ack for every request, reads registered with it
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         // no answer pending after reset
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= dpm_pkg::DATA_ZERO;
      end else begin
         WB_ACK_O <= bus_req;
         // writes leave the last read data in place
         if (bus_req && !WB_WE_I) begin
            WB_DAT_O <= rd_data;
         end
      end
   end

endmodule // dpm_mute_arb
`default_nettype wire

// ### verilog/dpm_pkg.sv
// constants shared by the dual pot mute and arbitration block
`default_nettype none
package dpm_pkg;
   // serial shift word layout
   localparam int WORD_W       = 16;
   localparam int POS_W        = 6;
   localparam int CH0_POS_LSB  = 0;
   localparam int CH1_POS_LSB  = 8;
   localparam int CH0_MUTE_BIT = 6;
   localparam int CH1_MUTE_BIT = 14;
   localparam logic [POS_W-1:0]  POS_MAX   = 6'h3F;
   localparam logic [POS_W-1:0]  POS_MIN   = 6'h00;
   localparam logic [POS_W-1:0]  POS_RESET = 6'h00;
   localparam logic [POS_W-1:0]  POS_ONE   = 6'h01;
   localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

   // pushbutton line indices
   localparam int BTN_N        = 6;
   localparam int BTN_VOL_UP   = 0;
   localparam int BTN_VOL_DN   = 1;
   localparam int BTN_C0_UP    = 2;
   localparam int BTN_C0_DN    = 3;
   localparam int BTN_C1_UP    = 4;
   localparam int BTN_C1_DN    = 5;
   localparam int IN_MUTE      = 6;
   localparam int IN_N         = 7;

   // wishbone register map (byte addresses)
   localparam int ADR_W = 8;
   localparam logic [ADR_W-1:0] ADR_CTRL   = 8'h00;
   localparam logic [ADR_W-1:0] ADR_STATUS = 8'h04;
   localparam logic [ADR_W-1:0] ADR_WORD   = 8'h08;
   localparam int CTRL_PB_EN_BIT  = 0;
   localparam int CTRL_HW_CLR_BIT = 1;
   localparam logic CTRL_PB_EN_RESET = 1'b1;
   localparam int ST_HW_MUTE_BIT  = 0;
   localparam int ST_SER_BUSY_BIT = 1;
   localparam int ST_MUTE0_BIT    = 2;
   localparam int ST_MUTE1_BIT    = 3;
   localparam int ST_LOADED_BIT   = 4;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   // debounce timing
   localparam int CORE_CLK_KHZ     = 250000;
   localparam int DEBOUNCE_MS      = 1;
   localparam int DEBOUNCE_CYCLES  = DEBOUNCE_MS * CORE_CLK_KHZ;
endpackage : dpm_pkg
`default_nettype wire

// ### verilog/dpm_debounce.sv
// three-flop synchroniser and debouncer for one active-low contact input
`default_nettype none
module dpm_debounce #(
   parameter int DEB_CYCLES = 250000,
   parameter int CNT_W      = $clog2(DEB_CYCLES + 1)
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic raw_n_i,
   output logic      level_n_o,
   output logic      press_o
);
   logic             s1_reg;    // first stage, read only by s2
   logic             s2_reg;    // second stage
   logic             s3_reg;    // third stage
   logic [CNT_W-1:0] cnt_reg;   // cycles the synchronised level has differed
   logic             level_reg; // debounced level, idle high

   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEB_CYCLES - 1);

   // synchroniser chain
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end else begin
         s1_reg <= raw_n_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts only once stages two and three agree for the full time
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg   <= '0;
         level_reg <= 1'b1;
         press_o   <= 1'b0;
      end else begin
         press_o <= 1'b0;
         if (s2_reg != s3_reg || s3_reg == level_reg) begin
            // bounce or no change: restart timing
            cnt_reg <= '0;
         end else if (cnt_reg == CNT_LAST) begin
            // stable long enough: accept, pulse on a new press
            cnt_reg   <= '0;
            level_reg <= s3_reg;
            press_o   <= ~s3_reg;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   assign level_n_o = level_reg;
endmodule // dpm_debounce
`default_nettype wire

// ### test/dpm_mute_arb_checker.sv
// checker for mute and serial load behaviour at the top ports
`default_nettype none
module dpm_mute_arb_checker #(
   parameter int DEBOUNCE_CYCLES = 8
) (
   input wire logic                      CORE_CLK_I,
   input wire logic                      RSTN_I,
   input wire logic                      SER_CLK_I,
   input wire logic                      SER_EN_I,
   input wire logic                      SER_DATA_I,
   input wire logic                      MUTE_N_I,
   input wire logic [dpm_pkg::POS_W-1:0] WIPER0_POS_O,
   input wire logic [dpm_pkg::POS_W-1:0] WIPER1_POS_O,
   input wire logic                      WIPER0_LOW_O,
   input wire logic                      WIPER1_LOW_O
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] shift_reg; // copy of the serial word
   logic [3:0]  quiet_reg; // core cycles since enable low
   logic [7:0]  low_reg;   // core cycles mute pin low
   logic        quiet;     // no serial load pending
   assign quiet = (quiet_reg >= 4'hA);
   // shift in at the top, lsb arrives first
   always_ff @(posedge SER_CLK_I) begin
      if (SER_EN_I) begin
         shift_reg <= {SER_DATA_I, shift_reg[15:1]};
      end
   end
   // count quiet cycles after the enable
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I || SER_EN_I) begin
         quiet_reg <= 4'h0;
      end else if (quiet_reg != 4'hF) begin
         quiet_reg <= quiet_reg + 4'h1;
      end
   end
   // count cycles the mute pin stays low
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I || MUTE_N_I) begin
         low_reg <= 8'h00;
      end else if (low_reg != 8'hFF) begin
         low_reg <= low_reg + 8'h01;
      end
   end
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RSTN_I);
   chk_reset_unmuted: assert property (
      $rose(RSTN_I) |-> (!WIPER0_LOW_O && !WIPER1_LOW_O) [*4]) else $error("mute active after reset");
   chk_mute_both_a: assert property (
      quiet && $rose(WIPER0_LOW_O) |-> WIPER1_LOW_O) else $error("channel 0 muted alone");
   chk_mute_both_b: assert property (
      quiet && $rose(WIPER1_LOW_O) |-> WIPER0_LOW_O) else $error("channel 1 muted alone");
   chk_mute_holds_pos: assert property (
      quiet && ($rose(WIPER0_LOW_O) || $rose(WIPER1_LOW_O)) |-> $stable(WIPER0_POS_O) && $stable(WIPER1_POS_O))
      else $error("mute moved a wiper");
   chk_mute_debounced: assert property (
      quiet && $rose(WIPER0_LOW_O) |-> low_reg >= DEBOUNCE_CYCLES) else $error("mute taken too soon");
   chk_busy_no_move: assert property (
      SER_EN_I && $past(SER_EN_I, 8) |-> $stable(WIPER0_POS_O) && $stable(WIPER1_POS_O))
      else $error("wiper moved during serial frame");
   chk_load_positions: assert property (
      $fell(SER_EN_I) |-> ##7 WIPER0_POS_O == shift_reg[5:0] && WIPER1_POS_O == shift_reg[13:8])
      else $error("loaded positions wrong");
   chk_load_soft_mute: assert property (
      $fell(SER_EN_I) |-> ##7 (!shift_reg[6] || WIPER0_LOW_O) && (!shift_reg[14] || WIPER1_LOW_O))
      else $error("soft mute flag ignored");
   cov_mute_rise: cover property (quiet && $rose(WIPER0_LOW_O));
   cov_mute_fall: cover property (quiet && $fell(WIPER1_LOW_O));
   cov_frame_end: cover property ($fell(SER_EN_I));
endmodule // dpm_mute_arb_checker
`default_nettype wire

// ### test/dpm_ser_host.sv
// serial controller model driving the three-wire port
`default_nettype none
module dpm_ser_host (
   output logic ser_clk_o,
   output logic ser_en_o,
   output logic ser_data_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // clock stands low, enable off outside frames
   initial begin
      ser_clk_o = 1'b0;
      ser_en_o = 1'b0;
      ser_data_o = 1'b1;
   end
   // raise enable and clock a whole word in
   task automatic shift_word(input logic [15:0] w, input int half);
      #7;
      ser_en_o = 1'b1;
      #60;
      for (int i = 0; i < 16; i++) begin
         ser_data_o = w[i];
         #(half);
         ser_clk_o = 1'b1;
         #(half);
         ser_clk_o = 1'b0;
      end
      ser_data_o = ~ser_data_o; // held value no longer valid
   endtask
   // drop enable so the word loads
   task automatic end_frame();
      #13;
      ser_en_o = 1'b0;
   endtask
endmodule // dpm_ser_host
`default_nettype wire

// ### test/test_dpm_mute_arb.sv
// self-checking bench for the mute and arbitration block
`default_nettype none
module test_dpm_mute_arb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DEB = 8;     // short debounce
   logic        clk = 1'b0;    // core clock
   logic        rst_n = 1'b0;  // active-low reset
   logic        cyc = 1'b0;    // bus cycle
   logic        stb = 1'b0;    // bus strobe
   logic        we = 1'b0;     // bus write
   logic [7:0]  adr = 8'h00;   // bus address
   logic [31:0] wdat = 32'h0;  // bus write data
   logic [31:0] rdat;          // bus read data
   logic        ack;           // bus acknowledge
   logic [6:0]  in_n = 7'h7F;  // contact inputs, idle high
   logic        sclk;          // serial clock
   logic        sen;           // serial enable
   logic        sdat;          // serial data
   logic [5:0]  pos0;          // wiper 0 setting
   logic [5:0]  pos1;          // wiper 1 setting
   logic        low0;          // wiper 0 muted
   logic        low1;          // wiper 1 muted
   logic [5:0]  p0;            // expected wiper 0
   logic [5:0]  p1;            // expected wiper 1
   logic [5:0]  d0 [6] = '{6'h01, 6'h3F, 6'h01, 6'h3F, 6'h00, 6'h00}; // steps per button
   logic [5:0]  d1 [6] = '{6'h01, 6'h3F, 6'h00, 6'h00, 6'h01, 6'h3F};
   logic [15:0] words [4] = '{16'h4A45, 16'h0A45, 16'h4A05, 16'h8C83}; // serial words
   int          mismatches = 0;
   int          n_tests = 0;
   int          cycles = 0;
   always #2 clk = ~clk;
   dpm_ser_host host (.ser_clk_o(sclk), .ser_en_o(sen), .ser_data_o(sdat));
   dpm_mute_arb #(.DEBOUNCE_CYCLES(DEB)) dut (
      .CORE_CLK_I(clk), .RSTN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .SER_CLK_I(sclk), .SER_EN_I(sen), .SER_DATA_I(sdat), .MUTE_N_I(in_n[dpm_pkg::IN_MUTE]),
      .VOLUME_UP_BUTTON_N_I(in_n[0]), .VOLUME_DOWN_BUTTON_N_I(in_n[1]),
      .CHAN0_UP_BUTTON_N_I(in_n[2]), .CHAN0_DOWN_BUTTON_N_I(in_n[3]),
      .CHAN1_UP_BUTTON_N_I(in_n[4]), .CHAN1_DOWN_BUTTON_N_I(in_n[5]),
      .WIPER0_POS_O(pos0), .WIPER1_POS_O(pos1), .WIPER0_LOW_O(low0), .WIPER1_LOW_O(low1));
   // print the verdict and stop
   task automatic wrap_up();
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end
   // compare one value
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one classic bus cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      q = 32'hxxxx_xxxx;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      // wait for the answer; only the bench timeout ends a hang
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // read and compare
   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(what, exp, q);
   endtask
   // write and wait for the effect
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
      @(posedge clk);
      chk("ack drop", 32'h0, {31'h0, ack});
      repeat (3) @(posedge clk);
   endtask
   // hold one contact low n cycles, then release
   task automatic press(input int i, input int n);
      in_n[i] <= 1'b0;
      repeat (n) @(posedge clk);
      in_n[i] <= 1'b1;
      repeat (3 * DEB) @(posedge clk);
   endtask
   // compare all wiper outputs
   task automatic outs(input logic [5:0] e0, input logic [5:0] e1, input logic l0, input logic l1);
      chk("wiper0 pos", {26'h0, e0}, {26'h0, pos0});
      chk("wiper1 pos", {26'h0, e1}, {26'h0, pos1});
      chk("wiper lows", {30'h0, l1, l0}, {30'h0, low1, low0});
   endtask
   // send a word and let it load
   task automatic frame(input logic [15:0] w, input int half);
      host.shift_word(w, half);
      host.end_frame();
      repeat (10) @(posedge clk);
   endtask
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      outs(6'h00, 6'h00, 1'b0, 1'b0);
      rd("ctrl", dpm_pkg::ADR_CTRL, 32'h1);
      rd("status", dpm_pkg::ADR_STATUS, 32'h0);
      rd("unmapped", 8'h0C, 32'h0);
      host.shift_word(16'h2A15, 32);
      repeat (10) @(posedge clk);
      outs(6'h00, 6'h00, 1'b0, 1'b0);
      host.end_frame();
      repeat (10) @(posedge clk);
      outs(6'h15, 6'h2A, 1'b0, 1'b0);
      foreach (words[k]) begin
         frame(words[k], (k == 1) ? 96 : 32);
         outs(words[k][5:0], words[k][13:8], words[k][6], words[k][14]);
         rd("word", dpm_pkg::ADR_WORD, {16'h0, words[k]});
      end
      press(dpm_pkg::IN_MUTE, 3);
      outs(6'h03, 6'h0C, 1'b0, 1'b0);
      press(dpm_pkg::IN_MUTE, DEB + 8);
      outs(6'h03, 6'h0C, 1'b1, 1'b1);
      press(dpm_pkg::IN_MUTE, DEB + 8);
      outs(6'h03, 6'h0C, 1'b0, 1'b0);
      p0 = 6'h03;
      p1 = 6'h0C;
      for (int b = 0; b < dpm_pkg::BTN_N; b++) begin
         press(dpm_pkg::IN_MUTE, DEB + 8);
         outs(p0, p1, 1'b1, 1'b1);
         press(b, DEB + 8);
         p0 = p0 + d0[b];
         p1 = p1 + d1[b];
         outs(p0, p1, 1'b0, 1'b0);
      end
      host.shift_word(16'h1122, 32);
      @(posedge clk);
      rd("status busy", dpm_pkg::ADR_STATUS, 32'h12);
      press(dpm_pkg::BTN_C0_UP, DEB + 8);
      outs(6'h03, 6'h0C, 1'b0, 1'b0);
      host.end_frame();
      repeat (10) @(posedge clk);
      outs(6'h22, 6'h11, 1'b0, 1'b0);
      wr(dpm_pkg::ADR_CTRL, 32'h0);
      press(dpm_pkg::BTN_C1_UP, DEB + 8);
      outs(6'h22, 6'h11, 1'b0, 1'b0);
      press(dpm_pkg::IN_MUTE, DEB + 8);
      outs(6'h22, 6'h11, 1'b1, 1'b1);
      rd("status muted", dpm_pkg::ADR_STATUS, 32'h1D);
      wr(dpm_pkg::ADR_CTRL, 32'h3);
      outs(6'h22, 6'h11, 1'b0, 1'b0);
      rd("ctrl", dpm_pkg::ADR_CTRL, 32'h1);
      wrap_up();
   end
endmodule // test_dpm_mute_arb
bind dpm_mute_arb dpm_mute_arb_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_chk (
   .CORE_CLK_I, .RSTN_I, .SER_CLK_I, .SER_EN_I, .SER_DATA_I, .MUTE_N_I,
   .WIPER0_POS_O, .WIPER1_POS_O, .WIPER0_LOW_O, .WIPER1_LOW_O);
`default_nettype wire
